// >>> hw/sbt_defs.svh
// constants for the scan test port
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH
`define SBT_IR_LEN       3
`define SBT_ID_LEN       32
`define SBT_BSR_LEN      69
`define SBT_OP_EXTEST    3'h0
`define SBT_OP_IDCODE    3'h1
`define SBT_OP_SAMPLEZ   3'h2
`define SBT_OP_SAMPLE    3'h4
`define SBT_OP_BYPASS    3'h7
`define SBT_IR_CAPTURE   3'h1
`define SBT_ID_REV_LSB   29
`define SBT_ID_PART_LSB  12
`define SBT_ID_MAKER_LSB 1
`define SBT_RESET_EDGES  5
`endif

// >>> hw/sbt_pkg.sv
// types for the scan test port
package sbt_pkg;
    typedef enum logic [15:0] {
        TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
        SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
        UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
        E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
    } sbt_state_e;
endpackage

// >>> hw/sbt_status_if.sv
// status passed from the scan clock domain to the system domain
`timescale 1ns/1ps
interface sbt_status_if;
    logic outputsOff;
    logic tapReset;
    modport src (output outputsOff, output tapReset);
    modport dst (input  outputsOff, input  tapReset);
endinterface

// >>> hw/sbt_sync.sv
// three-stage level synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module sbt_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1Q;
    logic s2Q;
    logic s3Q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1Q <= 1'b0;
            s2Q <= 1'b0;
            s3Q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                dout <= s3Q;
            end
        end
    end
endmodule

// >>> hw/sbt_tap.sv
// boundary scan test access port of the sram
`timescale 1ns/1ps
`include "sbt_defs.svh"
// Summary of operation
// - sample/preload: Capture-DR latches all pin levels into boundary register
// - capturing a changing pin may latch either value, harmlessly
// - Shift-DR puts boundary register between serial in and out
// - Update-DR under sample loads nothing, acts like Pause-DR
// - bypass instruction routes Shift-DR through single-bit bypass register
// - id value: revision 31:29, part 28:12, maker 11:1, bit0 one
// - path lengths: instruction 3, bypass 1, id 32, boundary 69
// - code 000 captures ring, selects boundary register, outputs stay driven
// - code 001 loads and selects identification register
// - code 010 captures ring, selects boundary register, floats outputs
// - code 100 captures ring, selects boundary register, no preload
// - code 111 selects bypass register, no sram effect
// - five high mode select edges reset port, load identification code
// - Capture-IR loads the two low instruction bits with 01
// - sample inputs on rising edge, msb in, lsb out on falling
module sbt_tap #(
    parameter logic [2:0]  REVISION = 3'h0,
    parameter logic [16:0] PART_ID  = 17'h0_0042, // arbitrary value
    parameter logic [10:0] MAKER_ID = 11'h055     // arbitrary value
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    testClk,
    input  wire logic                    testModeSel,
    input  wire logic                    testDataIn,
    output logic                         testDataOut,
    output logic                         testDataOutEn,
    input  wire logic [`SBT_BSR_LEN-1:0] pinRing,
    output logic                         dataOutFloat,
    output logic                         tapInReset
);
    sbt_pkg::sbt_state_e      stateQ;
    sbt_pkg::sbt_state_e      stateD;
    // path lengths fixed by width macros
    logic [`SBT_IR_LEN-1:0]   irShiftQ;
    logic [`SBT_IR_LEN-1:0]   irQ;
    logic                     bypassQ;
    logic [`SBT_ID_LEN-1:0]   idShiftQ;
    logic [`SBT_BSR_LEN-1:0]  bsrQ;
    logic [2:0]               tmsHighCntQ;
    logic                     selBsr;
    logic                     selId;
    logic                     serialBit;
    logic                     floatQ;
    logic [`SBT_ID_LEN-1:0]   idValue;
    sbt_status_if             stat ();

    assign idValue = {REVISION, PART_ID, MAKER_ID, 1'b1};

    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            sbt_pkg::TLR:  stateD = testModeSel ? sbt_pkg::TLR  : sbt_pkg::RTI;
            sbt_pkg::RTI:  stateD = testModeSel ? sbt_pkg::SDRS : sbt_pkg::RTI;
            sbt_pkg::SDRS: stateD = testModeSel ? sbt_pkg::SIRS : sbt_pkg::CDR;
            sbt_pkg::CDR:  stateD = testModeSel ? sbt_pkg::E1DR : sbt_pkg::SDR;
            sbt_pkg::SDR:  stateD = testModeSel ? sbt_pkg::E1DR : sbt_pkg::SDR;
            sbt_pkg::E1DR: stateD = testModeSel ? sbt_pkg::UDR  : sbt_pkg::PDR;
            sbt_pkg::PDR:  stateD = testModeSel ? sbt_pkg::E2DR : sbt_pkg::PDR;
            sbt_pkg::E2DR: stateD = testModeSel ? sbt_pkg::UDR  : sbt_pkg::SDR;
            sbt_pkg::UDR:  stateD = testModeSel ? sbt_pkg::SDRS : sbt_pkg::RTI;
            sbt_pkg::SIRS: stateD = testModeSel ? sbt_pkg::TLR  : sbt_pkg::CIR;
            sbt_pkg::CIR:  stateD = testModeSel ? sbt_pkg::E1IR : sbt_pkg::SIR;
            sbt_pkg::SIR:  stateD = testModeSel ? sbt_pkg::E1IR : sbt_pkg::SIR;
            sbt_pkg::E1IR: stateD = testModeSel ? sbt_pkg::UIR  : sbt_pkg::PIR;
            sbt_pkg::PIR:  stateD = testModeSel ? sbt_pkg::E2IR : sbt_pkg::PIR;
            sbt_pkg::E2IR: stateD = testModeSel ? sbt_pkg::UIR  : sbt_pkg::SIR;
            sbt_pkg::UIR:  stateD = testModeSel ? sbt_pkg::SDRS : sbt_pkg::RTI;
            default:       stateD = sbt_pkg::TLR;
        endcase
    end

    // rst stands in for the power-up reset of the scan domain
    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            stateQ <= sbt_pkg::TLR;
        end else begin
            stateQ <= stateD;
        end
    end

    // count of high mode select edges
    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            tmsHighCntQ <= 3'h0;
        end else if (!testModeSel) begin
            tmsHighCntQ <= 3'h0;
        end else if (tmsHighCntQ != 3'(`SBT_RESET_EDGES)) begin
            tmsHighCntQ <= tmsHighCntQ + 3'h1;
        end
    end

    // instruction shift path, capture pattern 01
    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            irShiftQ <= `SBT_OP_IDCODE;
        end else if (stateQ == sbt_pkg::CIR) begin
            irShiftQ <= `SBT_IR_CAPTURE;
        end else if (stateQ == sbt_pkg::SIR) begin
            irShiftQ <= {testDataIn, irShiftQ[`SBT_IR_LEN-1:1]};
        end
    end

    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            irQ <= `SBT_OP_IDCODE;
        end else if (stateQ == sbt_pkg::TLR) begin
            irQ <= `SBT_OP_IDCODE;
        end else if (stateQ == sbt_pkg::UIR) begin
            irQ <= irShiftQ;
        end
    end

    // boundary path select; reserved codes fall to bypass
    assign selBsr = (irQ == `SBT_OP_EXTEST) || (irQ == `SBT_OP_SAMPLEZ)
                 || (irQ == `SBT_OP_SAMPLE);
    assign selId  = (irQ == `SBT_OP_IDCODE);

    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            bypassQ <= 1'b0;
        end else if (stateQ == sbt_pkg::CDR) begin
            bypassQ <= 1'b0;
        end else if (stateQ == sbt_pkg::SDR && !selBsr && !selId) begin
            bypassQ <= testDataIn;
        end
    end

    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            idShiftQ <= '0;
        end else if (stateQ == sbt_pkg::CDR && selId) begin
            idShiftQ <= idValue;
        end else if (stateQ == sbt_pkg::SDR && selId) begin
            idShiftQ <= {testDataIn, idShiftQ[`SBT_ID_LEN-1:1]};
        end
    end

    // pin snapshot; a moving pin may land either way
    // shift boundary register; Update-DR touches nothing
    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            bsrQ <= '0;
        end else if (stateQ == sbt_pkg::CDR && selBsr) begin
            bsrQ <= pinRing;
        end else if (stateQ == sbt_pkg::SDR && selBsr) begin
            bsrQ <= {testDataIn, bsrQ[`SBT_BSR_LEN-1:1]};
        end
    end

    always_comb begin
        if (stateQ == sbt_pkg::SIR) begin
            serialBit = irShiftQ[0];
        end else if (selBsr) begin
            serialBit = bsrQ[0];
        end else if (selId) begin
            serialBit = idShiftQ[0];
        end else begin
            serialBit = bypassQ;
        end
    end

    // output changes on falling edge; driven only while shifting
    always_ff @(negedge testClk or posedge rst) begin
        if (rst) begin
            testDataOut   <= 1'b0;
            testDataOutEn <= 1'b0;
        end else begin
            testDataOut   <= serialBit;
            testDataOutEn <= (stateQ == sbt_pkg::SIR) || (stateQ == sbt_pkg::SDR);
        end
    end

    // float request; extest keeps drivers on
    always_ff @(posedge testClk or posedge rst) begin
        if (rst) begin
            floatQ <= 1'b0;
        end else begin
            floatQ <= (irQ == `SBT_OP_SAMPLEZ);
        end
    end

    assign stat.outputsOff = floatQ;
    assign stat.tapReset   = (stateQ == sbt_pkg::TLR);

    // test clock may stop, so levels cross into the system domain
    sbt_sync uFloatSync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (stat.outputsOff),
        .dout    (dataOutFloat)
    );

    sbt_sync uResetSync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (stat.tapReset),
        .dout    (tapInReset)
    );

    // assertions
    property fiveHighReset;
        @(posedge testClk) disable iff (rst)
        testModeSel [*5] |=> stateQ == sbt_pkg::TLR;
    endproperty
    tap_reset_a: assert property (fiveHighReset)
        else $error("five high mode edges did not reset");
    ir_capture_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CIR |=> irShiftQ[1:0] == 2'b01)
        else $error("capture-ir pattern wrong");
    id_load_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && irQ == `SBT_OP_IDCODE |=> idShiftQ == idValue)
        else $error("id not loaded");
    id_field_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && selId
        |=> idShiftQ[0] == 1'b1
            && idShiftQ[`SBT_ID_LEN-1:`SBT_ID_REV_LSB] == REVISION
            && idShiftQ[`SBT_ID_REV_LSB-1:`SBT_ID_PART_LSB] == PART_ID
            && idShiftQ[`SBT_ID_PART_LSB-1:`SBT_ID_MAKER_LSB] == MAKER_ID)
        else $error("id layout wrong");
    bsr_capture_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && irQ == `SBT_OP_SAMPLE
        |=> bsrQ == $past(pinRing))
        else $error("boundary capture missed");
    bsr_shift_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && selBsr
        |=> bsrQ[`SBT_BSR_LEN-2:0] == $past(bsrQ[`SBT_BSR_LEN-1:1]))
        else $error("boundary shift wrong");
    update_hold_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::UDR |=> $stable(bsrQ))
        else $error("update-dr altered boundary register");
    bypass_path_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && irQ == `SBT_OP_BYPASS |=> bypassQ == $past(testDataIn))
        else $error("bypass did not take input");
    extest_drive_a: assert property (@(posedge testClk) disable iff (rst)
        irQ == `SBT_OP_EXTEST |=> !floatQ)
        else $error("extest floated outputs");
    samplez_float_a: assert property (@(posedge testClk) disable iff (rst)
        irQ == `SBT_OP_SAMPLEZ |=> floatQ)
        else $error("sample-z did not float outputs");
    ir_update_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::UIR |=> irQ == $past(irShiftQ))
        else $error("instruction not updated");
    tdo_en_a: assert property (@(negedge testClk) disable iff (rst)
        stateQ == sbt_pkg::RTI |=> !testDataOutEn)
        else $error("output enabled outside shift");

    tms_count_a: assert property (@(posedge testClk) disable iff (rst)
        tmsHighCntQ == 3'(`SBT_RESET_EDGES)
        |-> stateQ == sbt_pkg::TLR)
        else $error("five high edges left port out of reset");
    tlr_idcode_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::TLR
        |=> irQ == `SBT_OP_IDCODE)
        else $error("reset state did not load id code");
    ir_hold_a: assert property (@(posedge testClk) disable iff (rst)
        !(stateQ inside {sbt_pkg::UIR, sbt_pkg::TLR})
        |=> $stable(irQ))
        else $error("instruction changed outside update");
    state_onehot_a: assert property (@(posedge testClk) disable iff (rst)
        $onehot(stateQ))
        else $error("controller state not one-hot");
    ir_shift_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SIR
        |=> irShiftQ == {$past(testDataIn), $past(irShiftQ[`SBT_IR_LEN-1:1])})
        else $error("instruction shift wrong");
    id_shift_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && selId
        |=> idShiftQ[`SBT_ID_LEN-1] == $past(testDataIn))
        else $error("id shift did not enter at msb");
    bsr_hold_a: assert property (@(posedge testClk) disable iff (rst)
        !(stateQ inside {sbt_pkg::CDR, sbt_pkg::SDR})
        |=> $stable(bsrQ))
        else $error("boundary register moved outside capture or shift");
    extest_capture_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && irQ == `SBT_OP_EXTEST
        |=> bsrQ == $past(pinRing))
        else $error("extest capture missed");
    samplez_capture_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && irQ == `SBT_OP_SAMPLEZ
        |=> bsrQ == $past(pinRing))
        else $error("sample-z capture missed");
    sample_drive_a: assert property (@(posedge testClk) disable iff (rst)
        irQ == `SBT_OP_SAMPLE
        |=> !floatQ)
        else $error("sample floated outputs");
    idcode_drive_a: assert property (@(posedge testClk) disable iff (rst)
        irQ == `SBT_OP_IDCODE
        |=> !floatQ)
        else $error("id code floated outputs");
    bypass_drive_a: assert property (@(posedge testClk) disable iff (rst)
        irQ == `SBT_OP_BYPASS
        |=> !floatQ)
        else $error("bypass floated outputs");
    bypass_clear_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR
        |=> !bypassQ)
        else $error("bypass bit not cleared on capture");
    bypass_hold_a: assert property (@(posedge testClk) disable iff (rst)
        (selBsr || selId) && stateQ != sbt_pkg::CDR
        |=> $stable(bypassQ))
        else $error("bypass bit moved while unselected");
    reserved_path_a: assert property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && !selBsr && !selId
        |=> bypassQ == $past(testDataIn))
        else $error("unselected codes did not shift through bypass");
    tdo_lsb_a: assert property (@(negedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && selBsr
        |=> testDataOut == $past(bsrQ[0]))
        else $error("serial out not boundary lsb");
    tdo_ir_a: assert property (@(negedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SIR
        |=> testDataOut == $past(irShiftQ[0]))
        else $error("serial out not instruction lsb");
    tdo_en_on_a: assert property (@(negedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR
        |=> testDataOutEn)
        else $error("output not enabled while shifting");

    shift_ir_c: cover property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::UIR);
    sample_c: cover property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::CDR && irQ == `SBT_OP_SAMPLE);
    bypass_c: cover property (@(posedge testClk) disable iff (rst)
        stateQ == sbt_pkg::SDR && irQ == `SBT_OP_BYPASS);
    float_c: cover property (@(posedge sys_clk) disable iff (rst) dataOutFloat);
    tap_reset_c: cover property (@(posedge testClk) disable iff (rst)
        tmsHighCntQ == 3'(`SBT_RESET_EDGES));
endmodule

// >>> dv/sbt_ctl_model.sv
// board test controller model driving the scan port
`timescale 1ns/1ps
module sbt_ctl_model (
    output logic      testClk,
    output logic      testModeSel,
    output logic      testDataIn,
    input  wire logic testDataOut,
    input  wire logic testDataOutEn
);
    realtime lowExtra;
    logic    lastTdo;
    initial begin
        testClk     = 1'b0;
        testModeSel = 1'b1;
        testDataIn  = 1'b1;
        lastTdo     = 1'b0;
        lowExtra    = 0;
    end
    // period 125 ns plus lowExtra, clock still between ticks
    // drive at the fall, sample out just before rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        testModeSel = tms;
        testDataIn  = tdi;
        #(62.5 + lowExtra);
        // released line seen as inverse of last, not a lucky match
        tdo     = testDataOutEn ? testDataOut : ~lastTdo;
        lastTdo = tdo;
        testClk = 1'b1;
        #62.5;
        testClk = 1'b0;
    endtask
    task automatic reset5();
        logic t;
        repeat (5) tick(1'b1, 1'b1, t);
    endtask
    task automatic idle();
        logic t;
        tick(1'b0, 1'b1, t);
    endtask
    // standard walk through the instruction column
    task automatic shiftIr(input logic [2:0] code, output logic [2:0] cap);
        logic t;
        tick(1'b1, 1'b1, t);
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
        tick(1'b0, 1'b1, t);
        for (int i = 0; i < 3; i++) begin
            tick(i == 2, code[i], t);
            cap[i] = t;
        end
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask
    // standard walk through the data column
    task automatic shiftDr(input int n, input logic [79:0] din, output logic [79:0] dout);
        logic t;
        dout = '0;
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
        tick(1'b0, 1'b1, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask
endmodule

// >>> dv/sram_boundary_scan_tap_tb_top.sv
// self-checking bench for the scan test port
`timescale 1ns/1ps
`include "sbt_defs.svh"
module sram_boundary_scan_tap_tb_top;
    localparam logic [2:0]  REV   = 3'h5;
    localparam logic [16:0] PART  = 17'h1_2345; // arbitrary value
    localparam logic [10:0] MAKER = 11'h2ab;    // arbitrary value
    localparam logic [79:0] DIN   = 80'hdead_beef_0123_4567_89ab;
    localparam logic [68:0] BASE  = 69'h15_a5a5_c3c3_0ff0_1234;
    logic        sys_clk, rst, testClk, testModeSel, testDataIn;
    logic        testDataOut, testDataOutEn, dataOutFloat, tapInReset;
    logic [68:0] pinRing;
    logic [79:0] got;
    logic [2:0]  cap;
    int          badCount, checksDone;
    sbt_tap #(.REVISION(REV), .PART_ID(PART), .MAKER_ID(MAKER)) sbt_tap_inst (
        .sys_clk(sys_clk), .rst(rst), .testClk(testClk), .testModeSel(testModeSel),
        .testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn),
        .pinRing(pinRing), .dataOutFloat(dataOutFloat), .tapInReset(tapInReset));
    sbt_ctl_model sbt_ctl_model_inst (
        .testClk(testClk), .testModeSel(testModeSel), .testDataIn(testDataIn),
        .testDataOut(testDataOut), .testDataOutEn(testDataOutEn));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chkBits(input logic [79:0] g, input logic [79:0] e);
        checksDone++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkFlag(input logic g, input logic e);
        checksDone++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bounded wait on a crossed status flag
    task automatic waitFlag(input logic useReset, input logic e);
        int i;
        for (i = 0; i < 40 && (useReset ? tapInReset : dataOutFloat) !== e; i++) begin
            @(negedge sys_clk);
        end
        if (i == 40) begin
            badCount++;
            reportAndStop();
        end
        chkFlag(useReset ? tapInReset : dataOutFloat, e);
    endtask
    // id path, 40 bits shifted so the length shows too
    task automatic testId();
        sbt_ctl_model_inst.shiftDr(40, DIN, got);
        chkBits(got, ((DIN << 32) | 80'({REV, PART, MAKER, 1'b1})) & ~({80{1'b1}} << 40));
        chkFlag(testDataOutEn, 1'b0);
    endtask
    task automatic testBypass();
        sbt_ctl_model_inst.lowExtra = 300;
        sbt_ctl_model_inst.shiftIr(`SBT_OP_BYPASS, cap);
        chkBits(80'(cap[1:0]), 80'h1);
        sbt_ctl_model_inst.shiftDr(12, DIN, got);
        chkBits(got, (DIN << 1) & ~({80{1'b1}} << 12));
        sbt_ctl_model_inst.lowExtra = 0;
    endtask
    task automatic testCapture(input logic [2:0] code);
        logic [68:0] pins;
        pins = BASE ^ (69'(code) << 60);
        @(negedge sys_clk);
        // pins held still, so no strobe bit needs masking
        pinRing = pins;
        sbt_ctl_model_inst.shiftIr(code, cap);
        sbt_ctl_model_inst.shiftDr(75, DIN, got);
        chkBits(got, ((DIN << 69) | 80'(pins)) & ~({80{1'b1}} << 75));
        waitFlag(1'b0, code == `SBT_OP_SAMPLEZ);
    endtask
    task automatic testTapReset();
        sbt_ctl_model_inst.reset5();
        waitFlag(1'b1, 1'b1);
        waitFlag(1'b0, 1'b0);
        sbt_ctl_model_inst.idle();
        testId();
    endtask
    initial begin
        rst         = 1'b1;
        pinRing     = '0;
        badCount    = 0;
        checksDone  = 0;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        sbt_ctl_model_inst.idle();
        testId();
        testBypass();
        // only implemented codes are ever loaded
        // extest keeps drivers on; floating needs sample-z (code 010)
        testCapture(`SBT_OP_EXTEST);
        testCapture(`SBT_OP_SAMPLE);
        testCapture(`SBT_OP_SAMPLEZ);
        testTapReset();
        reportAndStop();
    end
endmodule
